// ### core/mode_zero_core.sv
`timescale 1ns/1ps
// What this block does
// - Burst length comes from mode bits one..zero, for reads and writes.
// - Per-command mode: address bit twelve low picks chop, high picks eight beats.
// - Bursts wrap in aligned four or eight column blocks; low bits give start.
// - Mode bit three picks sequential or interleaved ordering.
// - Chop reads stay in start's group; last four slots drivers off.
// - Eight-beat sequential reads rotate low bits, then the other group.
// - Eight-beat interleaved reads give start XOR beat.
// - Chop writes use bit two only, ascending; last four beats ignored.
// - Eight-beat writes always go zero to seven ascending.
// - Chop and eight-beat accesses start internally at the same time.
// - Writing mode bit eight high starts DLL reset, then clears itself.
// - Write recovery from bits eleven..nine: 5,6,7,8,10,12,14.
// - Bit twelve low stops DLL in precharge power-down; slow exit.
// - Bit twelve high keeps DLL running in power-down; fast exit.
// - Read latency 5..14 whole cycles from bits six..four and two.
// - Read registered at edge n gives first data at edge n plus m.
module mode_zero_core
(
   input wire logic clk,
   input wire logic sys_rst,
   input wire mode_zero_pkg::cmd_t cmd,
   input wire logic precharge_pd,
   output mode_zero_pkg::cmd_t unused_cmd_echo_q,
   output logic [mode_zero_pkg::MR_W-1:0] mode_setup_zero_q,
   output logic [3:0] read_latency_cycles_q,
   output logic [3:0] write_recovery_q,
   output logic [2:0] rd_col_q,
   output logic rd_valid_q,
   output logic dq_oe_q,
   output logic [2:0] wr_col_q,
   output logic wr_en_q,
   output logic dll_reset_q,
   output logic dll_locked_q,
   output logic dll_on_q,
   output logic early_read_q
);
   import mode_zero_pkg::*;

   bl_mode_t bl_mode;
   logic chop_sel;
   burst_t new_rd;
   burst_t lat_q [0:LAT_DEPTH-1];
   burst_t tap;
   logic [2:0] rd_start_q;
   logic [2:0] rd_beat_q;
   logic rd_chop_q;
   logic rd_ilv_q;
   logic rd_run_q;
   logic rd_load;
   logic [2:0] rd_start_d;
   logic [2:0] rd_beat_d;
   logic [2:0] rd_col_d;
   logic [2:0] wr_start_q;
   logic [2:0] wr_beat_q;
   logic wr_chop_q;
   logic wr_run_q;
   logic [2:0] wr_start_d;
   logic [2:0] wr_beat_d;
   logic [2:0] wr_col_d;
   dll_state_t dll_state_q;
   logic [9:0] lock_cnt_q;
   logic [9:0] since_rst_q;
   logic [3:0] cl_d;
   logic [3:0] wr_d;

   // Burst length decode; the reserved code is treated as fixed eight
   assign bl_mode = bl_mode_t'(mode_setup_zero_q[BL_LSB+1:BL_LSB]);
   always_comb
   begin
      unique case (bl_mode)
         BL_FIXED4: chop_sel = 1'b1;
         BL_PER_CMD: chop_sel = ~cmd.addr[SEL_ADDR_BIT];
         BL_FIXED8: chop_sel = 1'b0;
         BL_RSVD: chop_sel = 1'b0;
      endcase
   end

   // Latency field: the extension bit selects the 12..14 range
   always_comb
   begin
      if (mode_setup_zero_q[CL_EXT_BIT])
         cl_d = CL_HI_BASE + {1'b0, mode_setup_zero_q[CL_LSB+2:CL_LSB]};
      else
         cl_d = CL_LO_BASE + {1'b0, mode_setup_zero_q[CL_LSB+2:CL_LSB]};
      if (cl_d < CL_MIN) // Reserved codes clamp so the latency tap stays in range
         cl_d = CL_MIN;
      if (cl_d > CL_MAX)
         cl_d = CL_MAX;
   end

   // Recovery field decode, whole cycles only
   always_comb
   begin
      unique case (mode_setup_zero_q[WR_LSB+2:WR_LSB])
         3'h1: wr_d = 4'h5;
         3'h2: wr_d = 4'h6;
         3'h3: wr_d = 4'h7;
         3'h4: wr_d = 4'h8;
         3'h5: wr_d = 4'hA;
         3'h6: wr_d = 4'hC;
         3'h7: wr_d = 4'hE;
         3'h0: wr_d = 4'h0; // Top encoding does not fit four bits; shown as zero
      endcase
   end

   // Mode word: loaded whole by the load command, DLL bit drops back after one cycle
   always_ff @(posedge clk)
   begin
      if (sys_rst)
         mode_setup_zero_q <= MR_RESET;
      else if (cmd.mrs)
         mode_setup_zero_q <= cmd.addr;
      else if (mode_setup_zero_q[DLL_RST_BIT])
         mode_setup_zero_q[DLL_RST_BIT] <= 1'b0;
   end

   // Decoded figures registered so they reach the pins from flops
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         read_latency_cycles_q <= CL_MIN;
         write_recovery_q <= 4'h0;
         unused_cmd_echo_q <= '0;
      end
      else
      begin
         read_latency_cycles_q <= cl_d;
         write_recovery_q <= wr_d;
         unused_cmd_echo_q <= cmd;
      end
   end

   // DLL reset and lock wait; the count restarts on every new reset request
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         dll_state_q <= DLL_OFF;
         lock_cnt_q <= 10'h000;
         dll_reset_q <= 1'b0;
         dll_locked_q <= 1'b0;
      end
      else
      begin
         dll_reset_q <= cmd.mrs & cmd.addr[DLL_RST_BIT];
         if (cmd.mrs && cmd.addr[DLL_RST_BIT])
         begin
            dll_state_q <= DLL_LOCKING;
            lock_cnt_q <= 10'h000;
            dll_locked_q <= 1'b0;
         end
         else
         begin
            unique case (dll_state_q)
               DLL_OFF: lock_cnt_q <= 10'h000;
               DLL_LOCKING:
               begin
                  lock_cnt_q <= lock_cnt_q + 10'h001;
                  if (lock_cnt_q == 10'(DLL_LOCK_CYCLES - 1))
                  begin
                     dll_state_q <= DLL_LOCKED;
                     dll_locked_q <= 1'b1;
                  end
               end
               DLL_LOCKED: lock_cnt_q <= lock_cnt_q;
               default: dll_state_q <= DLL_OFF;
            endcase
         end
      end
   end

   // DLL stops in precharge power-down only when the slow-exit mode is chosen
   always_ff @(posedge clk)
   begin
      if (sys_rst)
         dll_on_q <= 1'b0;
      else if (precharge_pd && !mode_setup_zero_q[PPD_BIT])
         dll_on_q <= 1'b0;
      else
         dll_on_q <= (dll_state_q != DLL_OFF);
   end

   // Reads during the DLL lock wait break output timing; flag it sticky for software
   always_ff @(posedge clk)
   begin
      if (sys_rst)
         early_read_q <= 1'b0;
      else if (cmd.rd && dll_state_q == DLL_LOCKING)
         early_read_q <= 1'b1;
   end

   // Read latency line; chop and full bursts take the same path and delay
   assign new_rd = '{vld: cmd.rd, chop: chop_sel, ilv: mode_setup_zero_q[BT_BIT],
                     col: cmd.addr[2:0]};
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         for (int i = 0; i < LAT_DEPTH; i++)
            lat_q[i] <= '0;
      end
      else
      begin
         lat_q[0] <= new_rd;
         for (int i = 1; i < LAT_DEPTH; i++)
            lat_q[i] <= lat_q[i-1];
      end
   end

   // Tap one short of the latency: the output flop adds the last cycle
   assign tap = lat_q[read_latency_cycles_q - 4'h1];
   assign rd_load = tap.vld;
   assign rd_start_d = rd_load ? tap.col : rd_start_q;
   assign rd_beat_d = rd_load ? 3'h0 : rd_beat_q + 3'h1;

   burst_order rd_order
   (
      .start(rd_start_d),
      .beat(rd_beat_d),
      .ilv(rd_load ? tap.ilv : rd_ilv_q),
      .wr(1'b0),
      .col(rd_col_d)
   );

   // Read beat engine; a chop keeps its slot length but turns drivers off late
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         rd_run_q <= 1'b0;
         rd_start_q <= 3'h0;
         rd_beat_q <= 3'h0;
         rd_chop_q <= 1'b0;
         rd_ilv_q <= 1'b0;
         rd_col_q <= 3'h0;
         rd_valid_q <= 1'b0;
         dq_oe_q <= 1'b0;
      end
      else if (rd_load || (rd_run_q && rd_beat_q != LAST_BEAT))
      begin
         rd_run_q <= 1'b1;
         rd_start_q <= rd_start_d;
         rd_beat_q <= rd_beat_d;
         if (rd_load)
         begin
            rd_chop_q <= tap.chop;
            rd_ilv_q <= tap.ilv;
         end
         rd_col_q <= rd_col_d;
         if ((rd_load ? tap.chop : rd_chop_q) && rd_beat_d >= 3'(CHOP_BEATS))
         begin
            rd_valid_q <= 1'b0;
            dq_oe_q <= 1'b0;
         end
         else
         begin
            rd_valid_q <= 1'b1;
            dq_oe_q <= 1'b1;
         end
      end
      else
      begin
         rd_run_q <= 1'b0;
         rd_valid_q <= 1'b0;
         dq_oe_q <= 1'b0;
      end
   end

   // Write start column: chop keeps only bit two, a full burst keeps nothing
   assign wr_start_d = cmd.wr ? (chop_sel ? {cmd.addr[2], 2'b00} : 3'h0) : wr_start_q;
   assign wr_beat_d = cmd.wr ? 3'h0 : wr_beat_q + 3'h1;

   burst_order wr_order
   (
      .start(wr_start_d),
      .beat(wr_beat_d),
      .ilv(1'b0),
      .wr(1'b1),
      .col(wr_col_d)
   );

   // Write beat engine starts on the command edge for either length
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         wr_run_q <= 1'b0;
         wr_start_q <= 3'h0;
         wr_beat_q <= 3'h0;
         wr_chop_q <= 1'b0;
         wr_col_q <= 3'h0;
         wr_en_q <= 1'b0;
      end
      else if (cmd.wr || (wr_run_q && wr_beat_q != LAST_BEAT))
      begin
         wr_run_q <= 1'b1;
         wr_start_q <= wr_start_d;
         wr_beat_q <= wr_beat_d;
         if (cmd.wr)
            wr_chop_q <= chop_sel;
         wr_col_q <= wr_col_d;
         wr_en_q <= !((cmd.wr ? chop_sel : wr_chop_q) && wr_beat_d >= 3'(CHOP_BEATS));
      end
      else
      begin
         wr_run_q <= 1'b0;
         wr_en_q <= 1'b0;
      end
   end

   // Checking aid: cycles since the last DLL reset request, saturating
   always_ff @(posedge clk)
   begin
      if (sys_rst)
         since_rst_q <= 10'h3FF;
      else if (cmd.mrs && cmd.addr[DLL_RST_BIT])
         since_rst_q <= 10'h000;
      else if (since_rst_q != 10'h3FF)
         since_rst_q <= since_rst_q + 10'h001;
   end

   a_dll_self_clear: assert property (@(posedge clk) disable iff (sys_rst)
      (cmd.mrs && cmd.addr[DLL_RST_BIT]) ##1 !cmd.mrs |-> mode_setup_zero_q[DLL_RST_BIT] ##1
      !mode_setup_zero_q[DLL_RST_BIT])
      else $error("DLL reset bit did not clear itself");

   a_dll_lock_wait: assert property (@(posedge clk) disable iff (sys_rst)
      $rose(dll_locked_q) |-> since_rst_q == 10'(DLL_LOCK_CYCLES))
      else $error("DLL lock not after 512 cycles");

   a_read_latency_min: assert property (@(posedge clk) disable iff (sys_rst)
      cmd.rd && read_latency_cycles_q == 4'h5 && !cmd.mrs |->
      ##6 (rd_valid_q && rd_beat_q == 3'h0))
      else $error("First read beat not at latency 5");

   a_read_latency_max: assert property (@(posedge clk) disable iff (sys_rst)
      cmd.rd && read_latency_cycles_q == 4'hE && !cmd.mrs |->
      ##15 (dq_oe_q && rd_beat_q == 3'h0))
      else $error("First read beat not at latency 14");

   a_chop_tristate: assert property (@(posedge clk) disable iff (sys_rst)
      rd_run_q && rd_chop_q && rd_beat_q >= 3'h4 |-> !dq_oe_q && !rd_valid_q)
      else $error("Drivers on in chop tail");

   a_seq_second_half: assert property (@(posedge clk) disable iff (sys_rst)
      rd_valid_q && !rd_chop_q && !rd_ilv_q && rd_beat_q == 3'h4 |->
      rd_col_q == {~rd_start_q[2], rd_start_q[1:0]} ##1 rd_col_q == {~rd_start_q[2], rd_start_q[1:0] + 2'h1})
      else $error("Sequential second group wrong");

   a_ilv_order: assert property (@(posedge clk) disable iff (sys_rst)
      rd_valid_q && rd_ilv_q |-> rd_col_q == (rd_start_q ^ rd_beat_q))
      else $error("Interleaved column wrong");

   a_read_in_block: assert property (@(posedge clk) disable iff (sys_rst)
      rd_valid_q && rd_chop_q |-> rd_col_q[2] == rd_start_q[2])
      else $error("Chop read left its block");

   a_wr_full_order: assert property (@(posedge clk) disable iff (sys_rst)
      wr_run_q && !wr_chop_q |-> wr_en_q && wr_col_q == wr_beat_q)
      else $error("Full write not ascending from zero");

   a_wr_chop_order: assert property (@(posedge clk) disable iff (sys_rst)
      cmd.wr && chop_sel |=> wr_en_q && wr_col_q == {$past(cmd.addr[2]), 2'b00} ##4 !wr_en_q [*4])
      else $error("Chop write order wrong");

   a_per_cmd_select: assert property (@(posedge clk) disable iff (sys_rst)
      cmd.rd && bl_mode == BL_PER_CMD |=> lat_q[0].chop == !$past(cmd.addr[SEL_ADDR_BIT]))
      else $error("Per-command burst choice ignored");

   a_ilv_capture: assert property (@(posedge clk) disable iff (sys_rst)
      cmd.rd |=> lat_q[0].ilv == $past(mode_setup_zero_q[BT_BIT]))
      else $error("Burst type not taken");

   a_latency_range: assert property (@(posedge clk) disable iff (sys_rst)
      ##1 (read_latency_cycles_q >= CL_MIN && read_latency_cycles_q <= CL_MAX))
      else $error("Read latency out of range");

   a_recovery_code: assert property (@(posedge clk) disable iff (sys_rst)
      mode_setup_zero_q[WR_LSB+2:WR_LSB] == 3'h5 |=> write_recovery_q == 4'hA)
      else $error("Recovery decode wrong");

   a_dll_pd_stop: assert property (@(posedge clk) disable iff (sys_rst)
      precharge_pd && !mode_setup_zero_q[PPD_BIT] |=> !dll_on_q)
      else $error("DLL ran in slow-exit power-down");

   a_dll_pd_run: assert property (@(posedge clk) disable iff (sys_rst)
      precharge_pd && mode_setup_zero_q[PPD_BIT] && dll_locked_q && !cmd.mrs |=> dll_on_q)
      else $error("DLL stopped in fast-exit power-down");

   a_fixed_chop: assert property (@(posedge clk) disable iff (sys_rst)
      cmd.wr && bl_mode == BL_FIXED4 |=> wr_chop_q)
      else $error("Fixed chop mode not applied");
endmodule : mode_zero_core

// ### common/mode_zero_pkg.sv
package mode_zero_pkg;
   // Field positions inside the mode setup zero word
   localparam int MR_W = 19;
   localparam int BL_LSB = 0;
   localparam int BT_BIT = 3;
   localparam int CL_LSB = 4;
   localparam int CL_EXT_BIT = 2;
   localparam int DLL_RST_BIT = 8;
   localparam int WR_LSB = 9;
   localparam int PPD_BIT = 12;
   localparam int SEL_ADDR_BIT = 12;
   localparam logic [MR_W-1:0] MR_RESET = 19'h00000;
   // Latency, DLL lock and burst figures in clock cycles
   localparam logic [3:0] CL_MIN = 4'h5;
   localparam logic [3:0] CL_MAX = 4'hE;
   localparam logic [3:0] CL_HI_BASE = 4'hC;
   localparam logic [3:0] CL_LO_BASE = 4'h4;
   localparam int LAT_DEPTH = 14;
   localparam int DLL_LOCK_CYCLES = 512;
   localparam int CHOP_BEATS = 4;
   localparam logic [2:0] LAST_BEAT = 3'h7;

   typedef enum logic [1:0]
   {
      BL_FIXED8 = 2'b00,
      BL_PER_CMD = 2'b01,
      BL_FIXED4 = 2'b10,
      BL_RSVD = 2'b11
   } bl_mode_t;

   typedef enum logic [1:0]
   {
      DLL_OFF = 2'b00,
      DLL_LOCKING = 2'b01,
      DLL_LOCKED = 2'b10
   } dll_state_t;

   // One command from the controller, sampled on a clock edge
   typedef struct packed
   {
      logic mrs;
      logic rd;
      logic wr;
      logic [MR_W-1:0] addr;
   } cmd_t;

   // Burst descriptor carried through the read latency line
   typedef struct packed
   {
      logic vld;
      logic chop;
      logic ilv;
      logic [2:0] col;
   } burst_t;
endpackage : mode_zero_pkg

// ### core/burst_order.sv
`timescale 1ns/1ps
// Column of one beat inside an eight-column block
module burst_order
(
   input wire logic [2:0] start,
   input wire logic [2:0] beat,
   input wire logic ilv,
   input wire logic wr,
   output logic [2:0] col
);
   // Writes stay ascending; reads rotate or interleave from the start
   always_comb
   begin
      if (wr)
         col = {start[2] ^ beat[2], beat[1:0]};
      else if (ilv)
         col = start ^ beat;
      else
         col = {start[2] ^ beat[2], start[1:0] + beat[1:0]};
   end
endmodule : burst_order

// ### tb/ctrl_model.sv
`timescale 1ns/1ps
// Behavioural memory controller that issues mode loads, reads and writes
module ctrl_model
(
   input wire logic clk,
   input wire logic sys_rst,
   output mode_zero_pkg::cmd_t cmd
);
   import mode_zero_pkg::*;

   // Reserved positions of the mode word that the controller always clears
   localparam logic [MR_W-1:0] RSVD = 19'h4E080;

   int cyc = 0;
   int mrs_cyc = -10;
   int dll_cyc = -1000;
   int busy_cyc = 0;

   initial cmd = '0;

   // Free cycle count used to space commands
   always @(posedge clk)
   begin
      cyc <= sys_rst ? 0 : cyc + 1;
   end

   // Recovery field from the recovery time and clock period, in picoseconds
   function automatic logic [2:0] wr_field(input int t_wr, input int t_ck);
      int c;
      c = (t_wr + t_ck - 1) / t_ck;
      return 3'(c <= 8 ? c - 4 : c / 2);
   endfunction : wr_field

   // One command {mrs, rd, wr}, held across exactly one rising edge
   task automatic issue(input logic [2:0] k, input logic [MR_W-1:0] a);
      @(negedge clk);
      while (k[1] && cyc < dll_cyc + DLL_LOCK_CYCLES) @(negedge clk);
      while (cyc < mrs_cyc + 3 || (k[2] && cyc < busy_cyc)) @(negedge clk);
      cmd.mrs = k[2];
      cmd.rd = k[1];
      cmd.wr = k[0];
      cmd.addr = k[2] ? (a & ~RSVD) : a;
      @(negedge clk);
      // Address lines move off the old value so a late sample is caught
      cmd.mrs = 1'b0;
      cmd.rd = 1'b0;
      cmd.wr = 1'b0;
      cmd.addr = ~cmd.addr;
      if (k[2])
      begin
         mrs_cyc = cyc;
      end
      if (k[2] && a[DLL_RST_BIT])
      begin
         dll_cyc = cyc;
      end
      if (k[1:0] != 2'b00)
      begin
         busy_cyc = cyc + 16;
      end
   endtask : issue
endmodule : ctrl_model

// ### tb/tb_top.sv
`timescale 1ns/1ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin miscompares++; \
   $display("ERROR %0t got %0h exp %0h", $time, g, e); end end
module tb_top;
   import mode_zero_pkg::*;

   localparam int CL_USE = 5;

   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   logic precharge_pd = 1'b0;
   cmd_t cmd;
   logic [MR_W-1:0] word;
   logic [MR_W-1:0] w;
   logic [3:0] lat;
   logic [3:0] rec;
   logic [2:0] rcol;
   logic [2:0] wcol;
   logic rvld, oe, wen, dllr, dlll, dllon, early, chop, a12;
   int miscompares = 0;
   int compares = 0;
   logic [3:0] rec_tab [8] = '{4'h0, 4'h5, 4'h6, 4'h7, 4'h8, 4'hA, 4'hC, 4'hE};
   logic [1:0] bl_tab [5] = '{2'b00, 2'b10, 2'b01, 2'b01, 2'b11};

   // 100 MHz clock
   always #5 clk = ~clk;

   ctrl_model u_ctrl (.clk(clk), .sys_rst(sys_rst), .cmd(cmd));

   mode_zero_core u_dut
   (
      .clk(clk),
      .sys_rst(sys_rst),
      .cmd(cmd),
      .precharge_pd(precharge_pd),
      .unused_cmd_echo_q(),
      .mode_setup_zero_q(word),
      .read_latency_cycles_q(lat),
      .write_recovery_q(rec),
      .rd_col_q(rcol),
      .rd_valid_q(rvld),
      .dq_oe_q(oe),
      .wr_col_q(wcol),
      .wr_en_q(wen),
      .dll_reset_q(dllr),
      .dll_locked_q(dlll),
      .dll_on_q(dllon),
      .early_read_q(early)
   );

   // Mode word from its fields; cl holds {field, extension bit}
   function automatic logic [MR_W-1:0] mk(input logic [1:0] bl, input logic bt, input logic [3:0] cl,
      input logic dll, input logic [2:0] wr, input logic ppd);
      logic [MR_W-1:0] v;
      v = '0;
      v[BL_LSB +: 2] = bl;
      v[BT_BIT] = bt;
      v[CL_LSB +: 3] = cl[3:1];
      v[CL_EXT_BIT] = cl[0];
      v[DLL_RST_BIT] = dll;
      v[WR_LSB +: 3] = wr;
      v[PPD_BIT] = ppd;
      return v;
   endfunction : mk

   task automatic close_out();
      if (miscompares == 0 && compares > 0)
      begin
         $display("verification passed");
      end
      else
      begin
         $display("verification failed");
      end
      $finish;
   endtask : close_out

   // One read or write burst, every beat slot checked at the falling edge
   task automatic burst(input logic wr, input logic bt, input logic [2:0] s);
      logic [2:0] b;
      logic [2:0] exp;
      logic on;
      logic [MR_W-1:0] a;
      a = '0;
      a[9:3] = 7'h55;
      a[SEL_ADDR_BIT] = a12;
      a[2:0] = s;
      u_ctrl.issue(wr ? 3'b001 : 3'b010, a);
      for (int i = 0; i < (wr ? 8 : CL_USE + 8); i++)
      begin
         b = wr ? 3'(i) : 3'(i - CL_USE);
         on = wr ? !(chop && i >= 4) : (i >= CL_USE) && !(chop && i >= CL_USE + 4);
         if (wr)
         begin
            exp = chop ? {s[2], b[1:0]} : b;
            `CHK(wen, on)
            if (on) `CHK(wcol, exp)
         end
         else
         begin
            exp = bt ? (s ^ b) : {s[2] ^ b[2], s[1:0] + b[1:0]};
            `CHK(rvld, on)
            `CHK(oe, on)
            if (on) `CHK(rcol, exp)
         end
         @(negedge clk);
      end
   endtask : burst

   // Main sequence
   initial
   begin
      repeat (20) @(negedge clk);
      sys_rst = 1'b0;
      @(negedge clk);
      `CHK(word, MR_RESET)
      `CHK(lat, CL_MIN)
      `CHK(rec, 4'h0)
      `CHK({rvld, oe, wen, dllr, dlll, dllon, early}, 7'h00)
      // DLL reset with reserved bits offered set; the controller clears them
      w = mk(2'b00, 1'b0, 4'h2, 1'b1, 3'h1, 1'b0);
      u_ctrl.issue(3'b100, w | 19'h4E080);
      `CHK(word, w)
      `CHK(dllr, 1'b1)
      @(negedge clk);
      `CHK(word[DLL_RST_BIT], 1'b0)
      `CHK(dllr, 1'b0)
      repeat (498) @(negedge clk);
      `CHK(dlll, 1'b0)
      repeat (20) @(negedge clk);
      `CHK(dlll, 1'b1)
      precharge_pd = 1'b1;
      repeat (2) @(negedge clk);
      `CHK(dllon, 1'b0)
      precharge_pd = 1'b0;
      repeat (2) @(negedge clk);
      `CHK(dllon, 1'b1)
      u_ctrl.issue(3'b100, mk(2'b00, 1'b0, 4'h2, 1'b0, u_ctrl.wr_field(15000, 2500), 1'b1));
      @(negedge clk);
      `CHK(rec, 4'h6)
      precharge_pd = 1'b1;
      repeat (2) @(negedge clk);
      `CHK(dllon, 1'b1)
      precharge_pd = 1'b0;
      // Every latency code from 5 to 14 and every recovery code
      for (int i = 0; i < 10; i++)
      begin
         u_ctrl.issue(3'b100, mk(2'b00, 1'b0, i < 7 ? {3'(i + 1), 1'b0} : {3'(i - 7), 1'b1}, 1'b0, 3'(i), 1'b0));
         @(negedge clk);
         `CHK(lat, 4'(5 + i))
         `CHK(rec, rec_tab[i % 8])
      end
      // All burst length codes, both orderings, every start column
      for (int j = 0; j < 5; j++)
      begin
         for (int bt = 0; bt < 2; bt++)
         begin
            a12 = (j == 1 || j == 3);
            chop = bl_tab[j] == 2'b10 || (bl_tab[j] == 2'b01 && !a12);
            u_ctrl.issue(3'b100, mk(bl_tab[j], 1'(bt), 4'h2, 1'b0, 3'h1, 1'b0));
            for (int s = 0; s < 8; s++)
            begin
               burst(1'b0, 1'(bt), 3'(s));
               burst(1'b1, 1'(bt), 3'(s));
            end
         end
      end
      `CHK(early, 1'b0)
      close_out();
   end

   // Watchdog well beyond the few thousand cycles the sequence needs
   initial
   begin
      repeat (20000) @(posedge clk);
      miscompares++;
      close_out();
   end
endmodule : tb_top
